//--- rtl/smc_defines.svh
// Opcodes, status bit positions, reset values and timing counts of the command front end
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// ------------------------------------------------------------
// Opcodes
// ------------------------------------------------------------
`define SMC_OP_SET_WRITE_LATCH   8'h06
`define SMC_OP_CLEAR_WRITE_LATCH 8'h04
`define SMC_OP_STATUS1_READ      8'h05
`define SMC_OP_STATUS1_WRITE     8'h01
`define SMC_OP_STATUS2_WRITE     8'h31
`define SMC_OP_ARRAY_READ        8'h03
`define SMC_OP_ARRAY_WRITE       8'h02
`define SMC_OP_ONETIME_PROGRAM   8'h9B
`define SMC_OP_ONETIME_PREFIX    8'h00
`define SMC_OP_ONETIME_READ      8'h77
`define SMC_OP_DEEP_SLEEP        8'h79

// ------------------------------------------------------------
// Status byte 1 and byte 2 bit positions
// ------------------------------------------------------------
`define SMC_S1_BUSY_BIT          0
`define SMC_S1_WEL_BIT           1
`define SMC_S1_BP_LO_BIT         2
`define SMC_S1_BP_HI_BIT         3
`define SMC_S1_SLEEP_BIT         4
`define SMC_S1_LOCK_BIT          7
`define SMC_S2_AUTO_SLEEP_BIT    0
`define SMC_S2_SLOW_OSC_BIT      1

// ------------------------------------------------------------
// Reset values and frame lengths in bytes
// ------------------------------------------------------------
`define SMC_RST_WEL              1'b0
`define SMC_RST_STATUS2          2'h0
`define SMC_LEN_SINGLE           3'h1
`define SMC_LEN_WITH_DATA        3'h2
`define SMC_LEN_ADDR_DATA        3'h4

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SMC_CLK_NS               100
`define SMC_WRITE_TIME_NS        200000
`define SMC_SLOW_ACTIVE_NS       50000
`define SMC_SLOW_IDLE_NS         50000
`define SMC_WRITE_CYCLES         (`SMC_WRITE_TIME_NS / `SMC_CLK_NS)
`define SMC_SLOW_ACTIVE_CYCLES   (`SMC_SLOW_ACTIVE_NS / `SMC_CLK_NS)
`define SMC_SLOW_IDLE_CYCLES     (`SMC_SLOW_IDLE_NS / `SMC_CLK_NS)

`endif

//--- rtl/smc_pkg.sv
// Types shared by the command front end
package smc_pkg;
  typedef logic [7:0] smc_byte_t;
  typedef enum logic [2:0] {ST_OPCODE, ST_ADDR, ST_DATA, ST_READ, ST_STAT_OUT, ST_IGNORE} smc_rx_e;
  typedef enum logic {WC_IDLE, WC_RUN} smc_wc_e;
  typedef enum logic [1:0] {K_ARRAY, K_STATUS1, K_STATUS2, K_ONETIME} smc_kind_e;
endpackage

//--- rtl/smc_fifo.sv
// Show-ahead FIFO with valid and ready on both sides
`timescale 1ns/1ps
module smc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  // Refused at elaboration: the pointers wrap correctly only at a power of two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin
    $error("smc_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign inReady  = (count != DEPTH[AW:0]);
  assign outValid = (count != '0);
  assign outData  = store[rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push)
      store[wrPtr] <= inData;
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push)
        wrPtr <= wrPtr + 1'b1;
      if (pop)
        rdPtr <= rdPtr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

//--- rtl/smc_cmd.sv
// Serial command front end of a small non-volatile memory: decode, status bytes, read stream, sleep
//
// Operation
// - Chip select idle and no write running: wait in standby for a command.
// - Deep sleep opcode puts the device into command-entered deep sleep.
// - Status byte 1 read does not wake; sleep flag reads 1 only while sleeping.
// - Auto-sleep on: sleep after array or status 1 write, not status 2.
// - Slow-oscillator on: alternate active and idle periods, lengthening writes.
// - Only the dedicated exit signal or power cycle ends deep sleep.
// - Decode write latch set, write latch clear and status 1 read codes.
// - Decode status byte 1 write and status byte 2 write codes.
// - Decode array read and array write codes.
// - One-time program needs the two-byte prefix; one-time read has its own code (0x77 is not decoded here, the frame is ignored).
// - Write latch clear after power-up; writes with latch clear are not executed.
// - Write latch cleared after latch clear, array, status 1 or status 2 write.
// - Chip select rising mid-byte: instruction fails, write latch unchanged.
// - Status 1 read returns protection bits, busy flag and write latch.
// - Status 1 write changes only the two protect bits and the lock bit.
// - Status 2 write sets both settings; master sets the write latch first.
// - Status 2 write sets busy; completion clears busy and the write latch.
// - Array read: opcode then two address bytes; only fifteen bits used.
// - After read opcode and address, further serial input is ignored.
// - Read data leaves most significant bit first, one byte per eight clocks.
// - Read address increments per byte and wraps to zero after the top.
// - Status 2: auto-sleep at bit 0, slow oscillator at bit 1, volatile.
// - Write latch reported at status 1 bit 1.
// - Sleep flag reported at status 1 bit 4.
`timescale 1ns/1ps
`include "smc_defines.svh"
module smc_cmd #(
  parameter int WRITE_CYCLES       = `SMC_WRITE_CYCLES,
  parameter int SLOW_ACTIVE_CYCLES = `SMC_SLOW_ACTIVE_CYCLES,
  parameter int SLOW_IDLE_CYCLES   = `SMC_SLOW_IDLE_CYCLES,
  parameter int FIFO_DEPTH         = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              chipSelN,
  input  wire logic              serClk,
  input  wire logic              serIn,
  output logic                   serOut,
  output logic                   serOutEn,
  input  wire logic              wakeReq,
  output logic [14:0]            memAddr,
  output logic                   memRdReq,
  input  wire smc_pkg::smc_byte_t memRdData,
  input  wire logic [2:0]        nvInit,
  output logic                   nvWrite,
  output logic [1:0]             blockProtect,
  output logic                   statusLock,
  output logic                   busy,
  output logic                   writeEnableLatch,
  output logic                   deepSleepFlag,
  output logic                   autoSleepAfterWrite,
  output logic                   slowOscillatorWrite,
  output logic                   oscSlowPhase
);
  import smc_pkg::*;

  if (WRITE_CYCLES < 1 || WRITE_CYCLES > 65535 || SLOW_ACTIVE_CYCLES < 1 || SLOW_ACTIVE_CYCLES > 65535 ||
      SLOW_IDLE_CYCLES < 1 || SLOW_IDLE_CYCLES > 65535) begin
    $error("smc_cmd: timing counts must lie in 1..65535");
  end

  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic [1:0] csSync;
  logic [1:0] sckSync;
  logic [1:0] sdiSync;
  logic [1:0] wakeSync;
  logic       csPrev;
  logic       sckPrev;
  logic       wakePrev;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      csSync   <= 2'h3;
      sckSync  <= 2'h0;
      sdiSync  <= 2'h0;
      wakeSync <= 2'h0;
      csPrev   <= 1'b1;
      sckPrev  <= 1'b0;
      wakePrev <= 1'b0;
    end else begin
      csSync   <= {csSync[0], chipSelN};
      sckSync  <= {sckSync[0], serClk};
      sdiSync  <= {sdiSync[0], serIn};
      wakeSync <= {wakeSync[0], wakeReq};
      csPrev   <= csSync[1];
      sckPrev  <= sckSync[1];
      wakePrev <= wakeSync[1];
    end
  end

  logic csActive;
  logic csRise;
  logic sckRise;
  logic sckFall;
  logic wakeRise;

  assign csActive = !csSync[1];
  assign csRise   = csSync[1] && !csPrev;
  assign sckRise  = csActive && sckSync[1] && !sckPrev;
  assign sckFall  = csActive && !sckSync[1] && sckPrev;
  assign wakeRise = wakeSync[1] && !wakePrev;

  // ------------------------------------------------------------
  // Byte receiver and opcode decoder
  // ------------------------------------------------------------
  smc_rx_e   state;
  logic [2:0] bitCnt;
  logic [2:0] byteCnt;
  smc_byte_t shiftIn;
  smc_byte_t opcode;
  smc_byte_t dataByte;
  smc_byte_t addrHi;
  logic      execOk;
  logic      prefixOk;
  logic      fetchOn;
  smc_byte_t rxByte;
  logic      byteDone;

  assign rxByte   = {shiftIn[6:0], sdiSync[1]};
  assign byteDone = sckRise && (bitCnt == 3'h7);

  always_ff @(posedge ref_clk) begin
    if (rst || !csActive) begin
      bitCnt  <= 3'h0;
      byteCnt <= 3'h0;
      shiftIn <= 8'h00;
    end else if (sckRise) begin
      bitCnt  <= bitCnt + 3'h1;
      shiftIn <= rxByte;
      if (bitCnt == 3'h7 && byteCnt != 3'h7)
        byteCnt <= byteCnt + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !csActive) begin
      state    <= ST_OPCODE;
      fetchOn  <= 1'b0;
      prefixOk <= 1'b0;
    end else if (byteDone) begin
      unique case (state)
        ST_OPCODE: begin
          execOk <= !(busy || deepSleepFlag);
          opcode <= rxByte;
          // only status reads are served while asleep or writing
          if (rxByte == `SMC_OP_STATUS1_READ)
            state <= ST_STAT_OUT;
          else if (busy || deepSleepFlag)
            state <= ST_IGNORE;
          else begin
            unique case (rxByte)
              `SMC_OP_ARRAY_READ, `SMC_OP_ARRAY_WRITE: state <= ST_ADDR;
              `SMC_OP_STATUS1_WRITE, `SMC_OP_STATUS2_WRITE,
              `SMC_OP_ONETIME_PROGRAM: state <= ST_DATA;
              default: state <= ST_IGNORE;
            endcase
          end
        end
        ST_ADDR: begin
          if (byteCnt == 3'h1)
            addrHi <= rxByte;
          else if (opcode == `SMC_OP_ARRAY_READ) begin
            state   <= ST_READ;
            fetchOn <= 1'b1;
          end else
            state <= ST_DATA;
        end
        ST_DATA: begin
          if (byteCnt == 3'h1)
            dataByte <= rxByte;
          // prefix bytes must both be zero
          if (byteCnt == 3'h1)
            prefixOk <= (rxByte == `SMC_OP_ONETIME_PREFIX);
          else if (byteCnt == 3'h2)
            prefixOk <= prefixOk && (rxByte == `SMC_OP_ONETIME_PREFIX);
        end
        // input ignored for the rest of the frame
        ST_READ, ST_STAT_OUT, ST_IGNORE: state <= state;
      endcase
    end
  end

  // Executed at chip select release, only on a whole number of bytes
  logic frameOk;
  logic doSetWel;
  logic doClrWel;
  logic doSleep;
  logic startS1;
  logic startS2;
  logic startArr;
  logic startOtp;
  logic startAny;

  assign frameOk  = csRise && (bitCnt == 3'h0) && execOk && (byteCnt != 3'h0);
  assign doSetWel = frameOk && opcode == `SMC_OP_SET_WRITE_LATCH && byteCnt == `SMC_LEN_SINGLE;
  assign doClrWel = frameOk && opcode == `SMC_OP_CLEAR_WRITE_LATCH && byteCnt == `SMC_LEN_SINGLE;
  assign doSleep  = frameOk && opcode == `SMC_OP_DEEP_SLEEP && byteCnt == `SMC_LEN_SINGLE;
  // writes need the latch; lock blocks status 1 writes
  assign startS1  = frameOk && writeEnableLatch && !statusLock && opcode == `SMC_OP_STATUS1_WRITE &&
                    byteCnt >= `SMC_LEN_WITH_DATA;
  assign startS2  = frameOk && writeEnableLatch && opcode == `SMC_OP_STATUS2_WRITE && byteCnt >= `SMC_LEN_WITH_DATA;
  assign startArr = frameOk && writeEnableLatch && opcode == `SMC_OP_ARRAY_WRITE && byteCnt >= `SMC_LEN_ADDR_DATA;
  assign startOtp = frameOk && writeEnableLatch && prefixOk && opcode == `SMC_OP_ONETIME_PROGRAM &&
                    byteCnt >= `SMC_LEN_ADDR_DATA;
  assign startAny = startS1 || startS2 || startArr || startOtp;

  // ------------------------------------------------------------
  // Self-timed write cycle with optional slow oscillator
  // ------------------------------------------------------------
  smc_wc_e   wcState;
  smc_kind_e wcKind;
  logic [15:0] wcTimer;
  logic [15:0] oscCnt;
  smc_byte_t  pendData;
  logic       wcDone;

  assign wcDone = (wcState == WC_RUN) && (wcTimer == 16'(WRITE_CYCLES - 1)) &&
                  !(slowOscillatorWrite && oscSlowPhase);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wcState <= WC_IDLE;
      wcKind  <= K_ARRAY;
      wcTimer <= 16'h0000;
      busy    <= 1'b0;
    end else begin
      unique case (wcState)
        WC_IDLE: begin
          wcTimer <= 16'h0000;
          if (startAny) begin
            wcState  <= WC_RUN;
            busy     <= 1'b1;
            pendData <= dataByte;
            wcKind   <= startS1 ? K_STATUS1 : startS2 ? K_STATUS2 : startArr ? K_ARRAY : K_ONETIME;
          end
        end
        WC_RUN: begin
          if (wcDone) begin
            wcState <= WC_IDLE;
            busy    <= 1'b0;
          end else if (!(slowOscillatorWrite && oscSlowPhase))
            wcTimer <= wcTimer + 16'h0001;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    // active and idle periods alternate during the write
    if (rst || wcState == WC_IDLE || !slowOscillatorWrite) begin
      oscCnt       <= 16'h0000;
      oscSlowPhase <= 1'b0;
    end else if (oscCnt == 16'(oscSlowPhase ? SLOW_IDLE_CYCLES - 1 : SLOW_ACTIVE_CYCLES - 1)) begin
      oscCnt       <= 16'h0000;
      oscSlowPhase <= !oscSlowPhase;
    end else
      oscCnt <= oscCnt + 16'h0001;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {statusLock, blockProtect} <= nvInit;
      nvWrite                    <= 1'b0;
    end else begin
      nvWrite <= 1'b0;
      // only protect and lock bits change
      if (wcDone && wcKind == K_STATUS1) begin
        blockProtect[0] <= pendData[`SMC_S1_BP_LO_BIT];
        blockProtect[1] <= pendData[`SMC_S1_BP_HI_BIT];
        statusLock      <= pendData[`SMC_S1_LOCK_BIT];
        nvWrite         <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      {slowOscillatorWrite, autoSleepAfterWrite} <= `SMC_RST_STATUS2;
    else if (wcDone && wcKind == K_STATUS2) begin
      autoSleepAfterWrite <= pendData[`SMC_S2_AUTO_SLEEP_BIT];
      slowOscillatorWrite <= pendData[`SMC_S2_SLOW_OSC_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      writeEnableLatch <= `SMC_RST_WEL;
    // cleared on completion of any write but one-time program, or on latch clear
    else if (doClrWel || (wcDone && wcKind != K_ONETIME))
      writeEnableLatch <= 1'b0;
    else if (doSetWel)
      writeEnableLatch <= 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      deepSleepFlag <= 1'b0;
    else if (deepSleepFlag && wakeRise)
      deepSleepFlag <= 1'b0;
    // command entry; auto entry after array or status 1 write
    else if (doSleep || (wcDone && autoSleepAfterWrite && (wcKind == K_ARRAY || wcKind == K_STATUS1)))
      deepSleepFlag <= 1'b1;
  end

  // ------------------------------------------------------------
  // Read fetch engine and prefetch buffer
  // ------------------------------------------------------------
  logic      rdPush;
  logic      fifoInReady;
  logic      fifoOutValid;
  logic      fifoPop;
  smc_byte_t fifoOutData;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      memAddr  <= 15'h0000;
      memRdReq <= 1'b0;
      rdPush   <= 1'b0;
    end else begin
      rdPush   <= memRdReq;
      memRdReq <= fetchOn && !memRdReq && !rdPush && fifoInReady;
      // only fifteen address bits are kept
      if (byteDone && state == ST_ADDR && byteCnt == 3'h2)
        memAddr <= {addrHi[6:0], rxByte};
      // increment per byte, wrapping at the top
      else if (rdPush && fetchOn)
        memAddr <= memAddr + 15'h0001;
    end
  end

  assign fifoPop = sckFall && (bitCnt == 3'h0) && (state == ST_READ);

  smc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_prefetch (
    .clk      (ref_clk),
    .rst      (rst),
    .flush    (!csActive),
    .inValid  (rdPush && fetchOn),
    .inReady  (fifoInReady),
    .inData   (memRdData),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData)
  );

  // ------------------------------------------------------------
  // Serial transmitter
  // ------------------------------------------------------------
  smc_byte_t status1;
  smc_byte_t txByte;
  smc_byte_t txShift;

  // status byte 1 layout; sleep bit
  always_comb begin
    status1                      = 8'h00;
    status1[`SMC_S1_BUSY_BIT]    = busy;
    status1[`SMC_S1_WEL_BIT]     = writeEnableLatch;
    status1[`SMC_S1_BP_LO_BIT]   = blockProtect[0];
    status1[`SMC_S1_BP_HI_BIT]   = blockProtect[1];
    status1[`SMC_S1_SLEEP_BIT]   = deepSleepFlag;
    status1[`SMC_S1_LOCK_BIT]    = statusLock;
  end

  // An empty buffer can only follow an out-of-range clock rate; it sends zeros
  assign txByte = (state == ST_STAT_OUT) ? status1 : (fifoOutValid ? fifoOutData : 8'h00);

  always_ff @(posedge ref_clk) begin
    if (rst || !csActive) begin
      serOut   <= 1'b0;
      txShift  <= 8'h00;
      serOutEn <= 1'b0;
    end else begin
      serOutEn <= (state == ST_READ) || (state == ST_STAT_OUT);
      // most significant bit first on falling edges
      if (sckFall && (state == ST_READ || state == ST_STAT_OUT)) begin
        if (bitCnt == 3'h0) begin
          serOut  <= txByte[7];
          txShift <= {txByte[6:0], 1'b0};
        end else begin
          serOut  <= txShift[7];
          txShift <= {txShift[6:0], 1'b0};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_wel_kept;
    @(posedge ref_clk) disable iff (rst) (csRise && bitCnt != 3'h0 && !busy) |=> $stable(writeEnableLatch);
  endproperty
  a_wel_kept: assert property (p_wel_kept) else $error("write latch changed on a broken frame");

  property p_wel_clear;
    @(posedge ref_clk) disable iff (rst) doClrWel |=> !writeEnableLatch;
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("latch clear command did not clear the latch");

  property p_sleep_enter;
    @(posedge ref_clk) disable iff (rst) doSleep |=> deepSleepFlag;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("deep sleep command not taken");

  property p_sleep_hold;
    @(posedge ref_clk) disable iff (rst) (deepSleepFlag && !wakeRise) |=> deepSleepFlag;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("left deep sleep without exit signal");

  property p_busy_s2;
    @(posedge ref_clk) disable iff (rst) startS2 |=> busy ##1 busy;
  endproperty
  a_busy_s2: assert property (p_busy_s2) else $error("status 2 write did not raise busy");

  property p_auto_sleep;
    @(posedge ref_clk) disable iff (rst)
      (wcDone && autoSleepAfterWrite && wcKind == K_STATUS1) |=> deepSleepFlag && !busy && !writeEnableLatch;
  endproperty
  a_auto_sleep: assert property (p_auto_sleep) else $error("no auto sleep after status 1 write");

  property p_out_released;
    @(posedge ref_clk) disable iff (rst) csSync[1] |=> !serOutEn;
  endproperty
  a_out_released: assert property (p_out_released) else $error("output driven outside a frame");

  property p_addr_wrap;
    @(posedge ref_clk) disable iff (rst) (rdPush && fetchOn && memAddr == 15'h7FFF && !byteDone) |=> memAddr == 15'h0000;
  endproperty
  a_addr_wrap: assert property (p_addr_wrap) else $error("read address did not wrap to zero");

  property p_read_sticky;
    @(posedge ref_clk) disable iff (rst) (state == ST_READ && csActive) ##1 csActive |-> state == ST_READ;
  endproperty
  a_read_sticky: assert property (p_read_sticky) else $error("input altered a running read");

  property p_standby;
    @(posedge ref_clk) disable iff (rst) !csActive |=> state == ST_OPCODE && bitCnt == 3'h0;
  endproperty
  a_standby: assert property (p_standby) else $error("not waiting for a command while deselected");
endmodule

//--- testbench/smc_mem_model.sv
// Array model answering read requests one cycle later
`timescale 1ns/1ps
module smc_mem_model (
  input  wire logic        clk,
  input  wire logic        memRdReq,
  input  wire logic [14:0] memAddr,
  output logic      [7:0]  memRdData
);
  // Pattern mixes both address bytes so a wrong increment shows
  always_ff @(posedge clk) begin
    if (memRdReq)
      memRdData <= memAddr[7:0] ^ {1'b0, memAddr[14:8]} ^ 8'hA5;
    else
      memRdData <= ~memRdData;
  end
endmodule

//--- testbench/tb_smc_cmd.sv
// Self-checking bench for the serial command front end
`timescale 1ns/1ps
module tb_smc_cmd;
  import smc_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, chipSelN = 1'b1, serClk = 1'b0, serIn = 1'b0, wakeReq = 1'b0;
  logic [2:0]  nvInit = 3'h1;
  logic        serOut, serOutEn, memRdReq, nvWrite, statusLock, busy, writeEnableLatch, deepSleepFlag;
  logic        autoSleepAfterWrite, slowOscillatorWrite, oscSlowPhase, sawSlow = 1'b0;
  logic        idleHigh = 1'b0, sawEn = 1'b0;
  logic [1:0]  blockProtect;
  logic [14:0] memAddr;
  smc_byte_t   memRdData;
  logic [15:0] rx;
  int          fails = 0, cmp_count = 0, cycles = 0, nvWrites = 0;

  smc_cmd #(.WRITE_CYCLES(20), .SLOW_ACTIVE_CYCLES(5), .SLOW_IDLE_CYCLES(5), .FIFO_DEPTH(16)) dut (
    .ref_clk, .rst, .chipSelN, .serClk, .serIn, .serOut, .serOutEn, .wakeReq, .memAddr, .memRdReq,
    .memRdData, .nvInit, .nvWrite, .blockProtect, .statusLock, .busy, .writeEnableLatch, .deepSleepFlag,
    .autoSleepAfterWrite, .slowOscillatorWrite, .oscSlowPhase);
  smc_mem_model mem (.clk(ref_clk), .memRdReq, .memAddr, .memRdData);

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (oscSlowPhase === 1'b1) sawSlow = 1'b1;
    if (serOutEn === 1'b1) sawEn = 1'b1;
    if (nvWrite === 1'b1) nvWrites++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] em(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]} ^ 8'hA5;
  endfunction

  // One bit: four ref cycles low and five high, output sampled late in the high phase; clock idles at idleHigh
  task automatic frame(input logic [39:0] b, input int nbits);
    logic [7:0] q;
    @(posedge ref_clk) chipSelN <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < nbits; i++) begin
      serClk <= 1'b0;
      serIn  <= b[39-i];
      repeat (4) @(posedge ref_clk);
      serClk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk) q = {q[6:0], serOut};
      @(posedge ref_clk);
      if (i % 8 == 7) rx = {rx[7:0], q};
    end
    serClk <= idleHigh;
    repeat (4) @(posedge ref_clk);
    chipSelN <= 1'b1;
    repeat (10) @(posedge ref_clk);
  endtask

  task automatic wait_idle();
    for (int k = 0; k < 300 && busy !== 1'b0; k++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic wake();
    @(posedge ref_clk) wakeReq <= 1'b1;
    repeat (6) @(posedge ref_clk);
    wakeReq <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask

  task report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({5'h0, writeEnableLatch, blockProtect}, 8'h01);
    frame({8'h06, 32'h0}, 8);
    chk({7'h0, writeEnableLatch}, 8'h01);
    frame({8'h05, 32'h0}, 16);
    chk(rx[7:0], 8'h06);
    chk({6'h0, sawEn, serOutEn}, 8'h02);
    sawEn = 1'b0;
    frame({8'h04, 32'h0}, 5);
    chk({7'h0, writeEnableLatch}, 8'h01);
    chk({7'h0, sawEn}, 8'h00);
    frame({8'h04, 32'h0}, 8);
    chk({7'h0, writeEnableLatch}, 8'h00);
    frame({16'h3103, 24'h0}, 16);
    wait_idle();
    chk({6'h0, slowOscillatorWrite, autoSleepAfterWrite}, 8'h00);
    frame({8'h06, 32'h0}, 8);
    frame({16'h3103, 24'h0}, 16);
    chk({7'h0, busy}, 8'h01);
    wait_idle();
    chk({4'h0, deepSleepFlag, slowOscillatorWrite, autoSleepAfterWrite, writeEnableLatch}, 8'h06);
    frame({8'h06, 32'h0}, 8);
    frame({16'h018C, 24'h0}, 16);
    wait_idle();
    chk({sawSlow, deepSleepFlag, statusLock, 3'h0, blockProtect}, 8'hE3);
    chk(8'(nvWrites), 8'h01);
    frame({8'h05, 32'h0}, 16);
    chk(rx[7:0], 8'h9C);
    frame({8'h06, 32'h0}, 8);
    chk({6'h0, deepSleepFlag, writeEnableLatch}, 8'h02);
    wake();
    chk({7'h0, deepSleepFlag}, 8'h00);
    frame({8'h79, 32'h0}, 8);
    chk({7'h0, deepSleepFlag}, 8'h01);
    wake();
    // Address top bit set on purpose: it must be dropped, and junk input ignored
    frame({8'h03, 32'hFFFF_FFFF}, 40);
    chk(rx[15:8], em(15'h7FFF));
    chk(rx[7:0], em(15'h0000));
    // One-time program: a nonzero prefix byte must leave it unexecuted
    frame({8'h06, 32'h0}, 8);
    frame({32'h9B00_0155, 8'h0}, 32);
    chk({7'h0, busy}, 8'h00);
    frame({32'h9B00_0055, 8'h0}, 32);
    chk({7'h0, busy}, 8'h01);
    wait_idle();
    // Array write keeps the latch from the prefix frames, then auto sleep follows
    frame({32'h0200_1055, 8'h0}, 32);
    chk({7'h0, busy}, 8'h01);
    wait_idle();
    chk({6'h0, deepSleepFlag, writeEnableLatch}, 8'h02);
    wake();
    // Clock idling high from here on
    idleHigh = 1'b1;
    serClk   <= 1'b1;
    frame({32'h0301_2300, 8'h0}, 32);
    chk(rx[7:0], em(15'h0123));
    frame({8'h05, 32'h0}, 16);
    chk(rx[7:0], 8'h8C);
    report_and_stop();
  end
endmodule
